// File: hdl/mas_pkg.sv
package mas_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   // register offsets
   localparam logic [7:0] OFS_START = 8'h40;
   localparam logic [7:0] OFS_STAT_P1 = 8'h41;
   localparam logic [7:0] OFS_STAT_P2 = 8'h42;
   localparam logic [7:0] OFS_SPECIAL = 8'h7c;
   localparam logic [7:0] OFS_TEMP_LEGACY = 8'h7e;
   localparam logic [7:0] OFS_CONFIG = 8'h7f;
   localparam logic [7:0] OFS_FAN_EN = 8'h80;
   localparam logic [7:0] OFS_TEMP_EN = 8'h82;
   localparam logic [7:0] OFS_STAT_S1 = 8'ha5;
   localparam logic [7:0] OFS_STAT_S2 = 8'ha6;
   // field positions
   localparam int START_BIT = 0;
   localparam int INIT_BIT = 7;
   localparam int GLOBAL_EN_BIT = 2;
   localparam int GROUP_EN_BIT = 0;
   localparam int TEMP_D1_BIT = 1;
   localparam int TEMP_AMB_BIT = 2;
   localparam int TEMP_D2_BIT = 3;
   localparam int FAN_LSB = 1;
   localparam int NUM_FANS = 3;
   // status layout: s1 {d2,amb,d1} in [2:0]; s2 {fan[2:0],flt2,flt1} in [4:0]
   localparam int S1_D1 = 0;
   localparam int S1_AMB = 1;
   localparam int S1_D2 = 2;
   localparam int S2_FLT1 = 0;
   localparam int S2_FLT2 = 1;
   localparam int S2_FAN_LSB = 2;
   // reset values
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] SPECIAL_RST = 8'h40;
   localparam logic [7:0] ENABLE_RST = 8'h00;
   localparam logic [7:0] START_RST = 8'h00;
   // forced readings
   localparam logic [7:0] FAULT_READING = 8'h80;
   localparam logic [7:0] DISABLED_FAULT_READING = 8'h00;

   typedef struct packed {
      logic open_pair;
      logic pos_to_vcc;
      logic pos_to_gnd;
      logic neg_to_vcc;
      logic neg_to_gnd;
   } mas_fault_type;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } mas_req_type;
endpackage : mas_pkg

// File: hdl/mas_alert_status.sv
`timescale 1ns/1ps
// Overview of operation
// - set status bit holds until one written or its register read, clearing only if its cause is gone
// - all status registers clear on main power reset, standby reset and soft init
// - primary status at 41h/42h, secondary at A5h/A6h, sharing one enable set
// - alert releases once no enabled primary alert bit is set; secondary never drives it
// - status bit never sets while its individual enable is clear
// - individual enables change only while the start bit is clear
// - disabled-but-set bit clears after restart at next reading update
// - any open or shorted diode terminal sets that diode's fault bit
// - a diode fault loads 80h into its reading, except negative-to-ground
// - reading of 80h sets the diode limit error bit, alerting when enabled
// - fault bits never drive the alert pin directly
// - disabled diode: fault bit stays clear, reading loads 00h, else normal value
// - temperature events need bit 0 of 82h, fan events bit 0 of 80h
// - alert pin active only with bit 2 of 7Ch set, otherwise released
// - temperature limit errors hold the pin low while error and enables stay set
// - fan error bits hold the pin low while fan alerting is enabled
// - reading a status register tries to clear bits whose cause is gone
// - alert pin may be active only while monitoring is started
// - monitor event sets thermal wake status whenever group enable is set
// - monitor event sets thermal management status, independent of pin enable
// - monitor event goes to serial interrupt frame chosen by select register
module mas_alert_status #(
   parameter int NUM_FANS_P = 3
) (
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic VCC_PWRGD,
   input wire mas_pkg::mas_req_type REG_REQ,
   output logic [mas_pkg::DATA_W-1:0] REG_RDATA,
   input wire logic [mas_pkg::NUM_FANS-1:0] FAN_ERR,
   input wire logic D1_LIMIT_ERR,
   input wire logic D2_LIMIT_ERR,
   input wire logic AMB_LIMIT_ERR,
   input wire mas_pkg::mas_fault_type D1_FAULT,
   input wire mas_pkg::mas_fault_type D2_FAULT,
   input wire logic [7:0] D1_RAW,
   input wire logic [7:0] D2_RAW,
   input wire logic D1_UPD,
   input wire logic D2_UPD,
   input wire logic AMB_UPD,
   input wire logic [mas_pkg::NUM_FANS-1:0] FAN_UPD,
   output logic [7:0] D1_READING,
   output logic [7:0] D2_READING,
   output logic MONITOR_START,
   output logic MONITOR_ALERT_PIN_O,
   output logic MONITOR_ALERT_PIN_OE,
   output logic MONITOR_EVENT,
   input wire logic WAKE_STS_CLR,
   output logic THERMAL_WAKE_STATUS,
   input wire logic MGMT_STS_CLR,
   output logic THERMAL_MGMT_STATUS,
   input wire logic [3:0] SERIRQ_SELECT,
   output logic SERIRQ_REQ,
   output logic [3:0] SERIRQ_FRAME
);
   import mas_pkg::*;

   if (NUM_FANS_P != NUM_FANS) begin : g_chk
      $error("fan count must match the status layout");
   end

   logic [7:0] start_q;
   logic [7:0] special_q;
   logic [7:0] legacy_q;
   logic [7:0] fan_en_q;
   logic [7:0] temp_en_q;
   logic [7:0] s1_q;
   logic [7:0] s2_q;
   logic [7:0] ss1_q;
   logic [7:0] ss2_q;
   logic [7:0] d1_rd_q;
   logic [7:0] d2_rd_q;
   logic [7:0] rdata_q;
   logic wake_q;
   logic mgmt_q;
   logic started;
   logic soft_init;
   logic status_clr;
   logic d1_on;
   logic d2_on;
   logic d1_flt;
   logic d2_flt;
   logic [7:0] stim1;
   logic [7:0] stim2;
   logic [7:0] en1;
   logic [7:0] en2;
   logic [7:0] upd1;
   logic [7:0] upd2;
   logic [7:0] s1_act;
   logic [7:0] s2_act;
   logic alert;

   function automatic logic hit(input mas_req_type r, input logic [7:0] a);
      hit = r.addr == a;
   endfunction : hit

   function automatic logic [7:0] w1c_mask(input mas_req_type r, input logic [7:0] a);
      w1c_mask = 8'h00;
      if (hit(r, a) && r.wr) begin
         w1c_mask = r.wdata;
      end else if (hit(r, a) && r.rd) begin
         w1c_mask = 8'hff;
      end
   endfunction : w1c_mask

   // sticky status update, set wins over clear
   function automatic logic [7:0] status_next(input logic [7:0] s, input logic [7:0] stim,
         input logic [7:0] en, input logic [7:0] upd, input logic [7:0] clr, input logic run);
      logic [7:0] set;
      logic [7:0] drop;
      set = stim & en & {8{run}};
      drop = (clr & ~stim) | (~en & upd & {8{run}});
      status_next = set | (s & ~drop);
   endfunction : status_next

   function automatic logic [7:0] force_reading(input mas_fault_type f, input logic on,
         input logic [7:0] raw);
      if (!(|f)) begin
         force_reading = raw;
      end else if (!on) begin
         force_reading = DISABLED_FAULT_READING;
      end else if (f.neg_to_gnd && !(f.open_pair || f.pos_to_vcc || f.pos_to_gnd
            || f.neg_to_vcc)) begin
         force_reading = raw;
      end else begin
         force_reading = FAULT_READING;
      end
   endfunction : force_reading

   assign started = start_q[START_BIT];
   assign soft_init = REG_REQ.wr && hit(REG_REQ, OFS_CONFIG) && REG_REQ.wdata[INIT_BIT];
   assign status_clr = soft_init || !VCC_PWRGD;
   assign d1_on = temp_en_q[TEMP_D1_BIT];
   assign d2_on = temp_en_q[TEMP_D2_BIT];
   assign d1_flt = (|D1_FAULT) && d1_on;
   assign d2_flt = (|D2_FAULT) && d2_on;

   always_comb begin
      stim1 = 8'h00;
      stim2 = 8'h00;
      en1 = 8'h00;
      en2 = 8'h00;
      upd1 = 8'h00;
      upd2 = 8'h00;
      stim1[S1_D1] = D1_LIMIT_ERR || d1_rd_q == FAULT_READING;
      stim1[S1_AMB] = AMB_LIMIT_ERR;
      stim1[S1_D2] = D2_LIMIT_ERR || d2_rd_q == FAULT_READING;
      stim2[S2_FLT1] = d1_flt;
      stim2[S2_FLT2] = d2_flt;
      stim2[S2_FAN_LSB +: NUM_FANS] = FAN_ERR;
      en1[S1_D1] = d1_on;
      en1[S1_AMB] = temp_en_q[TEMP_AMB_BIT];
      en1[S1_D2] = d2_on;
      en2[S2_FLT1] = d1_on;
      en2[S2_FLT2] = d2_on;
      en2[S2_FAN_LSB +: NUM_FANS] = fan_en_q[FAN_LSB +: NUM_FANS];
      upd1[S1_D1] = D1_UPD;
      upd1[S1_AMB] = AMB_UPD;
      upd1[S1_D2] = D2_UPD;
      upd2[S2_FLT1] = D1_UPD;
      upd2[S2_FLT2] = D2_UPD;
      upd2[S2_FAN_LSB +: NUM_FANS] = FAN_UPD;
   end

   // control registers
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         start_q <= START_RST;
         special_q <= SPECIAL_RST;
         legacy_q <= ENABLE_RST;
      end else if (soft_init) begin
         start_q <= START_RST;
         special_q <= SPECIAL_RST;
         legacy_q <= ENABLE_RST;
      end else if (REG_REQ.wr) begin
         if (hit(REG_REQ, OFS_START)) begin
            start_q <= REG_REQ.wdata;
         end
         if (hit(REG_REQ, OFS_SPECIAL)) begin
            special_q <= REG_REQ.wdata;
         end
         if (hit(REG_REQ, OFS_TEMP_LEGACY)) begin
            legacy_q <= REG_REQ.wdata;
         end
      end
   end

   // enable registers, frozen while started
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         fan_en_q <= ENABLE_RST;
         temp_en_q <= ENABLE_RST;
      end else if (soft_init) begin
         fan_en_q <= ENABLE_RST;
         temp_en_q <= ENABLE_RST;
      end else if (REG_REQ.wr && !started) begin
         if (hit(REG_REQ, OFS_FAN_EN)) begin
            fan_en_q <= REG_REQ.wdata;
         end
         if (hit(REG_REQ, OFS_TEMP_EN)) begin
            temp_en_q <= REG_REQ.wdata;
         end
      end
   end

   // diode reading registers, not touched by soft init
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         d1_rd_q <= 8'h00;
         d2_rd_q <= 8'h00;
      end else begin
         if (D1_UPD) begin
            d1_rd_q <= force_reading(D1_FAULT, d1_on, D1_RAW);
         end
         if (D2_UPD) begin
            d2_rd_q <= force_reading(D2_FAULT, d2_on, D2_RAW);
         end
      end
   end

   // primary and secondary status
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         s1_q <= STATUS_RST;
         s2_q <= STATUS_RST;
         ss1_q <= STATUS_RST;
         ss2_q <= STATUS_RST;
      end else if (status_clr) begin
         s1_q <= STATUS_RST;
         s2_q <= STATUS_RST;
         ss1_q <= STATUS_RST;
         ss2_q <= STATUS_RST;
      end else begin
         s1_q <= status_next(s1_q, stim1, en1, upd1, w1c_mask(REG_REQ, OFS_STAT_P1), started);
         s2_q <= status_next(s2_q, stim2, en2, upd2, w1c_mask(REG_REQ, OFS_STAT_P2), started);
         ss1_q <= status_next(ss1_q, stim1, en1, upd1, w1c_mask(REG_REQ, OFS_STAT_S1), started);
         ss2_q <= status_next(ss2_q, stim2, en2, upd2, w1c_mask(REG_REQ, OFS_STAT_S2), started);
      end
   end

   // register read data, one cycle after the read strobe
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         rdata_q <= 8'h00;
      end else if (REG_REQ.rd) begin
         case (REG_REQ.addr)
            OFS_START: rdata_q <= start_q;
            OFS_STAT_P1: rdata_q <= s1_q;
            OFS_STAT_P2: rdata_q <= s2_q;
            OFS_SPECIAL: rdata_q <= special_q;
            OFS_TEMP_LEGACY: rdata_q <= legacy_q;
            OFS_FAN_EN: rdata_q <= fan_en_q;
            OFS_TEMP_EN: rdata_q <= temp_en_q;
            OFS_STAT_S1: rdata_q <= ss1_q;
            OFS_STAT_S2: rdata_q <= ss2_q;
            default: rdata_q <= 8'h00;
         endcase
      end
   end

   // group-gated primary bits; fault bits excluded from the pin path
   always_comb begin
      s1_act = s1_q & en1 & {8{temp_en_q[GROUP_EN_BIT]}};
      s2_act = s2_q & en2 & {8{fan_en_q[GROUP_EN_BIT]}};
      s2_act[S2_FLT1] = 1'b0;
      s2_act[S2_FLT2] = 1'b0;
   end

   assign MONITOR_EVENT = (|s1_act) || (|s2_act);
   assign alert = MONITOR_EVENT && started && special_q[GLOBAL_EN_BIT];
   assign MONITOR_ALERT_PIN_O = 1'b0;
   assign MONITOR_ALERT_PIN_OE = alert;
   assign SERIRQ_REQ = MONITOR_EVENT;
   assign SERIRQ_FRAME = SERIRQ_SELECT;

   // wake and management status, set wins over clear
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         wake_q <= 1'b0;
         mgmt_q <= 1'b0;
      end else begin
         wake_q <= MONITOR_EVENT || (wake_q && !WAKE_STS_CLR);
         mgmt_q <= MONITOR_EVENT || (mgmt_q && !MGMT_STS_CLR);
      end
   end

   assign THERMAL_WAKE_STATUS = wake_q;
   assign THERMAL_MGMT_STATUS = mgmt_q;
   assign REG_RDATA = rdata_q;
   assign D1_READING = d1_rd_q;
   assign D2_READING = d2_rd_q;
   assign MONITOR_START = started;
endmodule : mas_alert_status

// File: bench/mas_alert_status_props.sv
`timescale 1ns/1ps
module mas_alert_status_props (
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic MONITOR_START,
   input wire logic MONITOR_ALERT_PIN_O,
   input wire logic MONITOR_ALERT_PIN_OE,
   input wire logic MONITOR_EVENT,
   input wire logic WAKE_STS_CLR,
   input wire logic THERMAL_WAKE_STATUS,
   input wire logic MGMT_STS_CLR,
   input wire logic THERMAL_MGMT_STATUS,
   input wire logic [3:0] SERIRQ_SELECT,
   input wire logic SERIRQ_REQ,
   input wire logic [3:0] SERIRQ_FRAME
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_B);
   a_alert_needs_start: assert property (MONITOR_ALERT_PIN_OE |-> MONITOR_START)
      else $error("alert active while stopped");
   a_pin_drives_low: assert property (MONITOR_ALERT_PIN_O == 1'b0)
      else $error("alert pin driven high");
   a_alert_has_event: assert property (MONITOR_ALERT_PIN_OE |-> MONITOR_EVENT)
      else $error("alert without enabled primary bit");
   a_wake_follows: assert property (MONITOR_EVENT |=> THERMAL_WAKE_STATUS)
      else $error("wake status missed event");
   a_mgmt_follows: assert property (MONITOR_EVENT |=> THERMAL_MGMT_STATUS)
      else $error("mgmt status missed event");
   a_wake_sticky: assert property ($fell(THERMAL_WAKE_STATUS) |-> $past(WAKE_STS_CLR))
      else $error("wake status dropped by itself");
   a_mgmt_sticky: assert property (THERMAL_MGMT_STATUS && !MGMT_STS_CLR |=>
      THERMAL_MGMT_STATUS) else $error("mgmt status dropped by itself");
   a_serirq_map: assert property (SERIRQ_REQ == MONITOR_EVENT &&
      SERIRQ_FRAME == SERIRQ_SELECT) else $error("serial irq mapping wrong");
endmodule : mas_alert_status_props

// File: bench/mas_host_model.sv
`timescale 1ns/1ps
module mas_host_model (
   input wire logic MCLK,
   output mas_pkg::mas_req_type REG_REQ,
   input wire logic [7:0] REG_RDATA
);
   import mas_pkg::*;
   initial REG_REQ = '0;
   // one byte strobe held for one edge, read data taken 1 ns after that same edge
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
         output logic [7:0] q);
      @(posedge MCLK);
      #1 REG_REQ = '{addr: a, wr: w, rd: !w, wdata: d};
      @(posedge MCLK);
      #1 REG_REQ = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
      q = REG_RDATA;
   endtask : acc
endmodule : mas_host_model

// File: bench/tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
   $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module tb;
   import mas_pkg::*;
   logic MCLK = 0, RST_B = 0, VCC_PWRGD = 1, D1_LIMIT_ERR = 0, D2_LIMIT_ERR = 0;
   logic AMB_LIMIT_ERR = 0, D1_UPD = 0, D2_UPD = 0, AMB_UPD = 0;
   logic WAKE_STS_CLR = 0, MGMT_STS_CLR = 0, MONITOR_START, MONITOR_ALERT_PIN_O;
   logic MONITOR_ALERT_PIN_OE, MONITOR_EVENT, THERMAL_WAKE_STATUS, THERMAL_MGMT_STATUS;
   logic SERIRQ_REQ;
   logic [2:0] FAN_ERR = 0, FAN_UPD = 0, e;
   logic [3:0] SERIRQ_SELECT = 0, SERIRQ_FRAME;
   logic [7:0] D1_RAW = 0, D2_RAW = 0, REG_RDATA, D1_READING, D2_READING, d, lf = 8'h1e;
   mas_fault_type D1_FAULT = '0, D2_FAULT = '0;
   mas_req_type REG_REQ;
   int num_errors = 0, compares = 0, cycles = 0;
   always #20 MCLK = ~MCLK;
   mas_host_model h (.MCLK, .REG_REQ, .REG_RDATA);
   mas_alert_status mas_alert_status_i (.MCLK, .RST_B, .VCC_PWRGD, .REG_REQ, .REG_RDATA,
      .FAN_ERR, .D1_LIMIT_ERR, .D2_LIMIT_ERR, .AMB_LIMIT_ERR, .D1_FAULT, .D2_FAULT,
      .D1_RAW, .D2_RAW, .D1_UPD, .D2_UPD, .AMB_UPD, .FAN_UPD, .D1_READING,
      .D2_READING, .MONITOR_START, .MONITOR_ALERT_PIN_O, .MONITOR_ALERT_PIN_OE,
      .MONITOR_EVENT, .WAKE_STS_CLR, .THERMAL_WAKE_STATUS, .MGMT_STS_CLR,
      .THERMAL_MGMT_STATUS, .SERIRQ_SELECT, .SERIRQ_REQ, .SERIRQ_FRAME);
   function automatic logic [7:0] nxt(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : nxt
   task automatic cyc(input int n);
      repeat (n) @(posedge MCLK);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      h.acc(1'b1, a, v, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      h.acc(1'b0, a, 8'h00, d);
      `CHK(d, x)
   endtask : rd
   task automatic close_out;
      $display("compares=%0d num_errors=%0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out
   always @(posedge MCLK) begin
      cycles++;
      if (cycles == 6000) begin
         num_errors++;
         close_out();
      end
   end
   initial begin
      #61 RST_B = 1;
      wr(OFS_START, 8'h01);
      lf = nxt(lf);
      e = lf[2:0] | 3'h1;
      {D2_LIMIT_ERR, AMB_LIMIT_ERR, D1_LIMIT_ERR} = e;
      cyc(3);
      rd(OFS_STAT_P1, 8'h00);
      wr(OFS_TEMP_EN, 8'h0f);
      rd(OFS_TEMP_EN, 8'h00);
      wr(OFS_START, 8'h00);
      wr(OFS_TEMP_EN, 8'h0f);
      wr(OFS_FAN_EN, 8'h0f);
      wr(OFS_SPECIAL, 8'h44);
      wr(OFS_START, 8'h01);
      cyc(1);
      `CHK(MONITOR_ALERT_PIN_OE, 1'b1)
      wr(OFS_STAT_P1, 8'hff);
      rd(OFS_STAT_P1, {5'h0, e});
      rd(OFS_STAT_S1, {5'h0, e});
      {D2_LIMIT_ERR, AMB_LIMIT_ERR, D1_LIMIT_ERR} = 3'h0;
      rd(OFS_STAT_P1, {5'h0, e});
      rd(OFS_STAT_P1, 8'h00);
      `CHK(MONITOR_ALERT_PIN_OE, 1'b0)
      wr(OFS_STAT_S1, 8'hff);
      e = lf[5:3] | 3'h1;
      FAN_ERR = e;
      cyc(1);
      `CHK(MONITOR_ALERT_PIN_OE, 1'b1)
      wr(OFS_SPECIAL, 8'h40);
      `CHK(MONITOR_ALERT_PIN_OE, 1'b0)
      rd(OFS_STAT_P2, {3'h0, e, 2'h0});
      wr(OFS_SPECIAL, 8'h44);
      `CHK(MONITOR_ALERT_PIN_OE, 1'b1)
      `CHK(THERMAL_WAKE_STATUS, 1'b1)
      FAN_ERR = 3'h0;
      wr(OFS_STAT_P2, 8'h1c);
      rd(OFS_STAT_P2, 8'h00);
      SERIRQ_SELECT = lf[3:0];
      WAKE_STS_CLR = 1;
      MGMT_STS_CLR = 1;
      cyc(1);
      WAKE_STS_CLR = 0;
      MGMT_STS_CLR = 0;
      cyc(1);
      `CHK({THERMAL_WAKE_STATUS, THERMAL_MGMT_STATUS}, 2'b00)
      `CHK(SERIRQ_FRAME, lf[3:0])
      for (int k = 0; k < 5; k++) begin
         D1_FAULT = mas_fault_type'(5'h1 << k);
         D1_RAW = 8'h25;
         D1_UPD = 1;
         cyc(1);
         D1_UPD = 0;
         cyc(1);
         `CHK(D1_READING, (k == 0) ? 8'h25 : FAULT_READING)
         `CHK(MONITOR_ALERT_PIN_OE, k != 0)
         rd(OFS_STAT_P2, 8'h01);
         D1_FAULT = '0;
         D1_UPD = 1;
         cyc(1);
         D1_UPD = 0;
         wr(OFS_STAT_P1, 8'hff);
         wr(OFS_STAT_P2, 8'hff);
         rd(OFS_STAT_P1, 8'h00);
      end
      D2_LIMIT_ERR = 1;
      cyc(1);
      `CHK(MONITOR_ALERT_PIN_OE, 1'b1)
      wr(OFS_START, 8'h00);
      `CHK({MONITOR_START, MONITOR_ALERT_PIN_OE}, 2'b00)
      wr(OFS_TEMP_EN, 8'h07);
      wr(OFS_START, 8'h01);
      rd(OFS_STAT_P1, 8'h04);
      D2_FAULT = mas_fault_type'(5'h10);
      D2_RAW = lf;
      D2_UPD = 1;
      cyc(1);
      D2_UPD = 0;
      `CHK(D2_READING, DISABLED_FAULT_READING)
      rd(OFS_STAT_P1, 8'h00);
      rd(OFS_STAT_P2, 8'h00);
      D2_FAULT = '0;
      D2_UPD = 1;
      cyc(1);
      D2_UPD = 0;
      `CHK(D2_READING, lf)
      D2_LIMIT_ERR = 0;
      wr(OFS_START, 8'h00);
      wr(OFS_TEMP_EN, 8'h06);
      wr(OFS_START, 8'h01);
      AMB_LIMIT_ERR = 1;
      MGMT_STS_CLR = 1;
      cyc(1);
      MGMT_STS_CLR = 0;
      cyc(1);
      `CHK({MONITOR_EVENT, SERIRQ_REQ, THERMAL_MGMT_STATUS}, 3'h0)
      rd(OFS_STAT_P1, 8'h02);
      FAN_ERR = 3'h2;
      cyc(2);
      `CHK({MONITOR_EVENT, SERIRQ_REQ, THERMAL_MGMT_STATUS}, 3'h7)
      AMB_LIMIT_ERR = 0;
      FAN_ERR = 3'h0;
      FAN_ERR = 3'h1;
      cyc(1);
      FAN_ERR = 3'h0;
      VCC_PWRGD = 0;
      cyc(1);
      VCC_PWRGD = 1;
      rd(OFS_STAT_P2, 8'h00);
      FAN_ERR = 3'h1;
      cyc(1);
      FAN_ERR = 3'h0;
      RST_B = 0;
      cyc(2);
      RST_B = 1;
      `CHK({MONITOR_START, MONITOR_EVENT, THERMAL_WAKE_STATUS}, 3'h0)
      rd(OFS_STAT_P2, 8'h00);
      wr(OFS_FAN_EN, 8'h0f);
      wr(OFS_SPECIAL, 8'h44);
      wr(OFS_START, 8'h01);
      FAN_ERR = 3'h1;
      cyc(1);
      FAN_ERR = 3'h0;
      `CHK(MONITOR_ALERT_PIN_OE, 1'b1)
      wr(OFS_CONFIG, 8'h80);
      rd(OFS_STAT_P2, 8'h00);
      rd(OFS_SPECIAL, SPECIAL_RST);
      close_out();
   end
endmodule : tb
bind mas_alert_status mas_alert_status_props p_i (.MCLK, .RST_B, .MONITOR_START,
   .MONITOR_ALERT_PIN_O, .MONITOR_ALERT_PIN_OE, .MONITOR_EVENT, .WAKE_STS_CLR,
   .THERMAL_WAKE_STATUS, .MGMT_STS_CLR, .THERMAL_MGMT_STATUS, .SERIRQ_SELECT,
   .SERIRQ_REQ, .SERIRQ_FRAME);
